// file: core/sam_activity_monitor.sv
/*
 * sam_activity_monitor: inactivity timer with its two 16-bit i/o registers,
 * activity qualification, timeout counter and inactivity flags.
 * assumes i/o strobes last one cycle per access, all inputs synchronous to
 * clk_sys, and slowTick pulses once per 3.90625 ms.
 */
`timescale 1ns/1ps

// Operation
// - writing enable zero puts the monitor idle and stops timing
// - writing enable one starts counting slow time-base ticks
// - unmasked activity while enabled clears the counter
// - reaching the timeout sets the inactivity flag and local attention
// - after a timeout the counter clears and timing restarts
// - coarse field times 64 seconds
// - fine field times about 7.8 ms
// - timeout never short, at most 3.9 ms longer
// - timeout is coarse delay plus fine delay
// - every unmasked listed source counts as activity; request bits only while control bit 15 is set
// - interrupt line 2 is never examined
// - requests on lines 3 and 4 gated by the controller's mask
// - control bit 15 enables all request-bit sources
// - mask bit 15 ignores chip-select i/o when set
// - mask bit 14 picks power-management input polarity
// - mask bits 13-11 pick power-management input or disable
// - mask bit 10 ignores the non-maskable output when set
// - mask bit 9 ignores disk data port i/o; counts only if enabled
// - mask bit 8 ignores coprocessor i/o when set
// - mask bits 7-6 pick attention line and exclude its bits
// - mask bits 5-0 mask request/in-service bits of lines 8, 7, 0
// - write zero to flag or disable clears all three status flags
// - activity while enabled sets after-flag if flagged or expiring, else before-flag
module sam_activity_monitor
    import sam_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [15:0] ioAddr,
    input  wire logic        ioWrStb,
    input  wire logic        ioRdStb,
    input  wire logic [15:0] ioWrData,
    output logic      [15:0] ioRdData,
    output logic             ioRdValid,
    input  wire logic        slowTick,
    input  wire logic [15:0] pendingRequestBits,
    input  wire logic [15:0] inServiceBits,
    input  wire logic [15:0] intMaskBits,
    input  wire logic [7:0]  powerMgmtPort,
    input  wire logic        nmiOut,
    input  wire logic        dmaCycle,
    input  wire logic        cpu16Bit,
    input  wire logic        busA23,
    input  wire logic        diskChipSelEnable,
    input  wire logic        chipSelHit,
    output logic             localAttention
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] attnLine(input logic [1:0] sel);
        unique case (sel)
            2'b00: attnLine = ATTN_LINE_SEL0;
            2'b01: attnLine = ATTN_LINE_SEL1;
            2'b10: attnLine = ATTN_LINE_SEL2;
            2'b11: attnLine = ATTN_LINE_SEL3;
        endcase
    endfunction

    // drop cascade line, attention line and the individually masked lines
    function automatic logic [15:0] qualifyLines(input logic [15:0] bits,
                                                 input logic [1:0]  attnSel,
                                                 input logic        m8,
                                                 input logic        m7,
                                                 input logic        m0);
        logic [15:0] q;
        q = bits;
        q[CASCADE_LINE]     = 1'b0;
        q[attnLine(attnSel)] = 1'b0;
        q[8] = q[8] & ~m8;
        q[7] = q[7] & ~m7;
        q[0] = q[0] & ~m0;
        qualifyLines = q;
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    sam_state_type      state_reg;
    logic [COUNT_W-1:0] count_reg;
    logic               irrEnable_reg;
    logic               testMode_reg;
    logic [7:0]         timeout_reg;
    logic [15:0]        mask_reg;
    logic               actLatch_reg;
    logic               inactFlag_reg;
    logic               actAfter_reg;
    logic               actBefore_reg;
    logic [15:0]        ioRdData_reg;
    logic               ioRdValid_reg;

    logic               ctrlWrite;
    logic               maskWrite;
    logic               disableWrite;
    logic               enableWrite;
    logic               flagClearWrite;
    logic [15:0]        irrQual;
    logic [15:0]        isrQual;
    logic [2:0]         pmSel;
    logic               pmActive;
    logic               levelRise;
    logic               coprocHit;
    logic               ioAccess;
    logic               ioActivity;
    logic               activity;
    logic [COUNT_W-1:0] timeoutLimit;
    logic [COUNT_W-1:0] countStep;
    logic [15:0]        ctrlView;

    assign ctrlWrite      = ioWrStb && (ioAddr == SAM_CTRL_PORT);
    assign maskWrite      = ioWrStb && (ioAddr == SAM_MASK_PORT);
    assign disableWrite   = ctrlWrite && !ioWrData[CTRL_ENABLE_BIT];
    assign enableWrite    = ctrlWrite && ioWrData[CTRL_ENABLE_BIT];
    assign flagClearWrite = ctrlWrite && !ioWrData[CTRL_INACT_BIT];

    // ------------------------------------------------------------------
    // activity qualification
    // ------------------------------------------------------------------
    always_comb begin
        irrQual = qualifyLines(pendingRequestBits, mask_reg[7:6],
                               mask_reg[MASK_IRR8_BIT], mask_reg[MASK_IRR7_BIT],
                               mask_reg[MASK_IRR0_BIT]);
        irrQual[GATED_LINE_A] = irrQual[GATED_LINE_A] & ~intMaskBits[GATED_LINE_A];
        irrQual[GATED_LINE_B] = irrQual[GATED_LINE_B] & ~intMaskBits[GATED_LINE_B];
        if (!irrEnable_reg) begin
            irrQual = 16'h0000;
        end
        isrQual = qualifyLines(inServiceBits, mask_reg[7:6],
                               mask_reg[MASK_ISR8_BIT], mask_reg[MASK_ISR7_BIT],
                               mask_reg[MASK_ISR0_BIT]);
    end

    assign pmSel = mask_reg[MASK_PM_SEL_LSB +: 3];

    // codes 6 and 7 select nothing
    always_comb begin
        pmActive = 1'b0;
        if (pmSel <= PM_SEL_LAST_INPUT) begin
            pmActive = powerMgmtPort[pmSel + PM_INPUT_BASE] ~^ mask_reg[MASK_PM_LEVEL_BIT];
        end
    end

    sam_edge_detect #(
        .WIDTH (35)
    ) u_levels (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .levels  ({irrQual, isrQual, pmActive,
                   nmiOut & ~mask_reg[MASK_NMI_BIT], dmaCycle}),
        .anyRise (levelRise)
    );

    // i/o strobes are already single-cycle events
    assign ioAccess  = ioWrStb || ioRdStb;
    assign coprocHit = cpu16Bit ? (ioAddr >= COPROC_PORT_LO && ioAddr <= COPROC_PORT_HI)
                                : busA23;
    assign ioActivity = ioAccess &&
                        ((!mask_reg[MASK_COPROC_BIT] && coprocHit) ||
                         (!mask_reg[MASK_DISK_BIT] && diskChipSelEnable &&
                          ioAddr == DISK_DATA_PORT) ||
                         (!mask_reg[MASK_CHIP_SEL_BIT] && chipSelHit));
    assign activity = levelRise || ioActivity;

    // ------------------------------------------------------------------
    // timeout arithmetic
    // ------------------------------------------------------------------
    // one extra tick covers the unknown phase of the first tick, so the
    // wait is never short and overshoots by less than one tick
    assign timeoutLimit = COUNT_W'(timeout_reg[7:4]) * COUNT_W'(COARSE_TICKS)
                        + COUNT_W'(timeout_reg[3:0]) * COUNT_W'(FINE_TICKS)
                        + RUN_STEP;
    assign countStep = testMode_reg ? TEST_STEP : RUN_STEP;

    // ------------------------------------------------------------------
    // monitor sequence
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
        end else if (disableWrite) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (enableWrite) begin
                        state_reg <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (!activity && count_reg >= timeoutLimit) begin
                        state_reg <= ST_EXPIRE;
                    end
                end
                ST_EXPIRE: begin
                    state_reg <= ST_COUNT;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (state_reg != ST_COUNT || activity || disableWrite) begin
            count_reg <= '0;
        end else if (slowTick && count_reg < timeoutLimit) begin
            count_reg <= count_reg + countStep;
        end
    end

    // ------------------------------------------------------------------
    // status flags: a set in the same cycle as a clear wins
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            inactFlag_reg <= 1'b0;
        end else if (state_reg == ST_EXPIRE) begin
            inactFlag_reg <= 1'b1;
        end else if (flagClearWrite || disableWrite) begin
            inactFlag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            actAfter_reg  <= 1'b0;
            actBefore_reg <= 1'b0;
        end else begin
            if (activity && state_reg != ST_IDLE &&
                (inactFlag_reg || state_reg == ST_EXPIRE)) begin
                actAfter_reg <= 1'b1;
            end else if (flagClearWrite || disableWrite) begin
                actAfter_reg <= 1'b0;
            end
            if (activity && state_reg == ST_COUNT && !inactFlag_reg) begin
                actBefore_reg <= 1'b1;
            end else if (flagClearWrite || disableWrite) begin
                actBefore_reg <= 1'b0;
            end
        end
    end

    // latches any unmasked activity, enabled or not
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            actLatch_reg <= 1'b0;
        end else if (activity) begin
            actLatch_reg <= 1'b1;
        end else if (ctrlWrite && !ioWrData[CTRL_ACT_LATCH_BIT]) begin
            actLatch_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // writable configuration
    // ------------------------------------------------------------------
    // timeout fields are taken whenever written; software keeps them still
    // while enabled, otherwise the running limit moves under the counter
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irrEnable_reg <= CTRL_RESET[CTRL_IRR_ENABLE_BIT];
            testMode_reg  <= CTRL_RESET[CTRL_TEST_MODE_BIT];
            timeout_reg   <= CTRL_RESET[7:0];
        end else if (ctrlWrite) begin
            irrEnable_reg <= ioWrData[CTRL_IRR_ENABLE_BIT];
            testMode_reg  <= ioWrData[CTRL_TEST_MODE_BIT];
            timeout_reg   <= ioWrData[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= MASK_RESET;
        end else if (maskWrite) begin
            mask_reg <= ioWrData;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    always_comb begin
        ctrlView = {irrEnable_reg, count_reg[COUNTER_TAP_BIT], testMode_reg,
                    actLatch_reg, inactFlag_reg, actAfter_reg, actBefore_reg,
                    state_reg != ST_IDLE, timeout_reg};
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ioRdData_reg  <= 16'h0000;
            ioRdValid_reg <= 1'b0;
        end else begin
            ioRdValid_reg <= ioRdStb &&
                             (ioAddr == SAM_CTRL_PORT || ioAddr == SAM_MASK_PORT);
            if (ioRdStb && ioAddr == SAM_CTRL_PORT) begin
                ioRdData_reg <= ctrlView;
            end else if (ioRdStb && ioAddr == SAM_MASK_PORT) begin
                ioRdData_reg <= mask_reg;
            end else begin
                ioRdData_reg <= 16'h0000;
            end
        end
    end

    assign ioRdData       = ioRdData_reg;
    assign ioRdValid      = ioRdValid_reg;
    assign localAttention = inactFlag_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence seqExpire;
        state_reg == ST_EXPIRE ##1 inactFlag_reg;
    endsequence

    a_disable_idle: assert property (disableWrite |=> state_reg == ST_IDLE && count_reg == '0)
        else $error("monitor not idle after disable");
    a_enable_start: assert property ((state_reg == ST_IDLE && enableWrite)
        |=> state_reg == ST_COUNT && count_reg == '0)
        else $error("monitor did not start counting");
    a_activity_clear: assert property ((state_reg == ST_COUNT && activity && !disableWrite)
        |=> count_reg == '0 && state_reg == ST_COUNT)
        else $error("activity did not clear counter");
    a_timeout_flag: assert property ((state_reg == ST_EXPIRE) |-> ##1 (inactFlag_reg && localAttention))
        else $error("timeout did not raise flag and attention");
    a_restart_seq: assert property ((state_reg == ST_EXPIRE && !disableWrite)
        |-> seqExpire ##0 (state_reg == ST_COUNT && count_reg == '0))
        else $error("timeout did not restart sequence");
    a_no_early: assert property ((state_reg == ST_COUNT && count_reg < timeoutLimit)
        |=> state_reg != ST_EXPIRE)
        else $error("timeout before programmed value");
    a_limit_sum: assert property (timeoutLimit == COUNT_W'(timeout_reg[7:4]) * 18'h04000
        + COUNT_W'(timeout_reg[3:0]) * 18'h00002 + 18'h00001)
        else $error("timeout limit not coarse plus fine");
    a_cascade_skip: assert property (!irrQual[CASCADE_LINE] && !isrQual[CASCADE_LINE])
        else $error("cascade line examined");
    a_master_gate: assert property (!irrEnable_reg |-> irrQual == 16'h0000)
        else $error("request bits used while master gate off");
    a_attn_excluded: assert property (!irrQual[attnLine(mask_reg[7:6])]
        && !isrQual[attnLine(mask_reg[7:6])])
        else $error("attention line counted as activity");
    a_flag_clear: assert property ((flagClearWrite && !activity && state_reg != ST_EXPIRE)
        |=> !inactFlag_reg && !actAfter_reg && !actBefore_reg)
        else $error("status flags not cleared");
    a_after_flag: assert property ((inactFlag_reg && activity && state_reg == ST_COUNT)
        |=> actAfter_reg)
        else $error("activity after flag not recorded");

endmodule

// file: core/sam_edge_detect.sv
/*
 * sam_edge_detect: turns a vector of activity levels into one pulse in
 * each cycle in which any bit rises.
 * assumes levels are synchronous to clk_sys.
 */
`timescale 1ns/1ps

module sam_edge_detect #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] levels,
    output logic                  anyRise
);

    logic [WIDTH-1:0] levels_reg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            levels_reg <= '0;
        end else begin
            levels_reg <= levels;
        end
    end

    // a level held high counts once, not every cycle
    assign anyRise = |(levels & ~levels_reg);

endmodule

// file: core/sam_pkg.sv
/*
 * sam_pkg: register ports, field positions, reset values, state codes and
 * time-base figures of the system activity monitor.
 * assumes the slow time base arrives as a one-cycle tick every 3.90625 ms.
 */
package sam_pkg;

    // ------------------------------------------------------------------
    // register ports (16-bit I/O ports)
    // ------------------------------------------------------------------
    localparam logic [15:0] SAM_CTRL_PORT = 16'hB072;
    localparam logic [15:0] SAM_MASK_PORT = 16'hD872;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_IRR_ENABLE_BIT = 15;
    localparam int CTRL_CNT_BIT12_BIT  = 14;
    localparam int CTRL_TEST_MODE_BIT  = 13;
    localparam int CTRL_ACT_LATCH_BIT  = 12;
    localparam int CTRL_INACT_BIT      = 11;
    localparam int CTRL_ACT_AFTER_BIT  = 10;
    localparam int CTRL_ACT_BEFORE_BIT = 9;
    localparam int CTRL_ENABLE_BIT     = 8;
    localparam int CTRL_COARSE_LSB     = 4;
    localparam int CTRL_FINE_LSB       = 0;
    localparam int COUNTER_TAP_BIT     = 12;

    // ------------------------------------------------------------------
    // mask register fields
    // ------------------------------------------------------------------
    localparam int MASK_CHIP_SEL_BIT   = 15;
    localparam int MASK_PM_LEVEL_BIT   = 14;
    localparam int MASK_PM_SEL_LSB     = 11;
    localparam int MASK_NMI_BIT        = 10;
    localparam int MASK_DISK_BIT       = 9;
    localparam int MASK_COPROC_BIT     = 8;
    localparam int MASK_ATTN_SEL_LSB   = 6;
    localparam int MASK_IRR8_BIT       = 5;
    localparam int MASK_IRR7_BIT       = 4;
    localparam int MASK_IRR0_BIT       = 3;
    localparam int MASK_ISR8_BIT       = 2;
    localparam int MASK_ISR7_BIT       = 1;
    localparam int MASK_ISR0_BIT       = 0;

    localparam logic [2:0] PM_SEL_LAST_INPUT = 3'h5;
    localparam logic [2:0] PM_INPUT_BASE     = 3'h2;
    localparam logic [3:0] ATTN_LINE_SEL0    = 4'h5;
    localparam logic [3:0] ATTN_LINE_SEL1    = 4'hA;
    localparam logic [3:0] ATTN_LINE_SEL2    = 4'hB;
    localparam logic [3:0] ATTN_LINE_SEL3    = 4'hF;
    localparam int CASCADE_LINE  = 2;
    localparam int GATED_LINE_A  = 3;
    localparam int GATED_LINE_B  = 4;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // i/o decode
    // ------------------------------------------------------------------
    localparam logic [15:0] COPROC_PORT_LO = 16'h00F8;
    localparam logic [15:0] COPROC_PORT_HI = 16'h00FF;
    localparam logic [15:0] DISK_DATA_PORT = 16'h01F0;

    // ------------------------------------------------------------------
    // timing, counted in slow ticks
    // ------------------------------------------------------------------
    localparam longint TICK_PERIOD_NS = 64'd3_906_250;
    localparam longint COARSE_STEP_NS = 64'd64_000_000_000;
    localparam longint FINE_STEP_NS   = 64'd7_812_500;
    localparam int COARSE_TICKS = int'(COARSE_STEP_NS / TICK_PERIOD_NS);
    localparam int FINE_TICKS   = int'(FINE_STEP_NS / TICK_PERIOD_NS);
    localparam int COUNT_W      = 18;
    localparam logic [COUNT_W-1:0] TEST_STEP = 18'h00200;
    localparam logic [COUNT_W-1:0] RUN_STEP  = 18'h00001;

    // ------------------------------------------------------------------
    // monitor states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_COUNT  = 3'b010,
        ST_EXPIRE = 3'b100
    } sam_state_type;

endpackage

// file: verification/sam_host_model.sv
/*
 * sam_host_model: host software side of the activity monitor i/o ports.
 * assumes one access per cycle and read data one cycle after the strobe.
 */
`timescale 1ns/1ps

module sam_host_model (
    input  wire logic        clk_sys,
    output logic      [15:0] ioAddr,
    output logic             ioWrStb,
    output logic             ioRdStb,
    output logic      [15:0] ioWrData,
    input  wire logic [15:0] ioRdData,
    input  wire logic        ioRdValid
);
    // ------------------------------------------------------------------
    // i/o cycles
    // ------------------------------------------------------------------
    initial begin
        ioAddr   = 16'h0000;
        ioWrStb  = 1'b0;
        ioRdStb  = 1'b0;
        ioWrData = 16'h0000;
    end

    task automatic ioWrite(input logic [15:0] addr, input logic [15:0] data);
        @(posedge clk_sys);
        ioAddr   <= addr;
        ioWrData <= data;
        ioWrStb  <= 1'b1;
        @(posedge clk_sys);
        ioWrStb  <= 1'b0;
        ioWrData <= ~data;
    endtask

    task automatic ioRead(input logic [15:0] addr, output logic [15:0] data,
                          output logic valid);
        @(posedge clk_sys);
        ioAddr  <= addr;
        ioRdStb <= 1'b1;
        @(posedge clk_sys);
        ioRdStb <= 1'b0;
        #1;
        data  = ioRdData;
        valid = ioRdValid;
    endtask

    // fields go in while disabled, enable follows in a separate write
    task automatic setTimeout(input logic [7:0] value);
        ioWrite(16'hB072, {8'h00, value});
        ioWrite(16'hB072, {8'h01, value});
    endtask
endmodule

// file: verification/system_activity_monitor_tb_top.sv
/*
 * system_activity_monitor_tb_top: register, timeout and activity scenarios.
 * assumes the slow tick is driven here, much faster than the real time base.
 */
`timescale 1ns/1ps

module system_activity_monitor_tb_top
    import sam_pkg::*;
;
    logic clk_sys, rstn, ioWrStb, ioRdStb, ioRdValid, slowTick, nmiOut, localAttention;
    logic dmaCycle, diskChipSelEnable, chipSelHit;
    logic [15:0] pendingRequestBits, inServiceBits;
    logic [7:0]  powerMgmtPort;
    logic [15:0] ioAddr, ioWrData, ioRdData, rd;
    logic        v;
    int          mismatches, checksDone;

    // ------------------------------------------------------------------
    // clock, design and host
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    sam_host_model host (.clk_sys(clk_sys), .ioAddr(ioAddr), .ioWrStb(ioWrStb),
        .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid));

    sam_activity_monitor dut (.clk_sys(clk_sys), .rstn(rstn), .ioAddr(ioAddr),
        .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData),
        .ioRdValid(ioRdValid), .slowTick(slowTick), .pendingRequestBits(pendingRequestBits),
        .inServiceBits(inServiceBits), .intMaskBits(16'h0000), .powerMgmtPort(powerMgmtPort),
        .nmiOut(nmiOut), .dmaCycle(dmaCycle), .cpu16Bit(1'b1), .busA23(1'b0),
        .diskChipSelEnable(diskChipSelEnable), .chipSelHit(chipSelHit),
        .localAttention(localAttention));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            slowTick <= 1'b1;
            @(posedge clk_sys);
            slowTick <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        rstn       = 1'b0;
        slowTick   = 1'b0;
        nmiOut     = 1'b0;
        dmaCycle   = 1'b0;
        chipSelHit = 1'b0;
        diskChipSelEnable  = 1'b0;
        pendingRequestBits = 16'h0000;
        inServiceBits      = 16'h0000;
        // power inputs idle high (inactive when active low): no false edge after reset
        powerMgmtPort      = 8'hFF;
        mismatches = 0;
        checksDone = 0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        host.ioRead(SAM_CTRL_PORT, rd, v);
        check("ctrl reset", CTRL_RESET, rd);
        check("ctrl valid", 16'h0001, {15'h0000, v});
        host.ioRead(SAM_MASK_PORT, rd, v);
        check("mask reset", MASK_RESET, rd);
        host.ioRead(16'h1234, rd, v);
        check("unmapped valid", 16'h0000, {15'h0000, v});
        // bit 10 clear keeps the non-maskable output counted as activity
        host.ioWrite(SAM_MASK_PORT, 16'hB9C3);
        host.ioRead(SAM_MASK_PORT, rd, v);
        check("mask readback", 16'hB9C3, rd);
        host.setTimeout(8'h00);
        tick(1);
        check("attn zero timeout", 16'h0001, {15'h0000, localAttention});
        host.ioRead(SAM_CTRL_PORT, rd, v);
        check("ctrl flagged", 16'h0900, rd);
        host.ioWrite(SAM_CTRL_PORT, 16'h0000);
        host.ioRead(SAM_CTRL_PORT, rd, v);
        check("ctrl cleared", 16'h0000, rd);
        check("attn cleared", 16'h0000, {15'h0000, localAttention});
        host.setTimeout(8'h01);
        tick(FINE_TICKS);
        check("attn early", 16'h0000, {15'h0000, localAttention});
        @(posedge clk_sys);
        nmiOut <= 1'b1;
        @(posedge clk_sys);
        nmiOut <= 1'b0;
        tick(FINE_TICKS);
        check("attn after activity", 16'h0000, {15'h0000, localAttention});
        tick(1);
        check("attn fine timeout", 16'h0001, {15'h0000, localAttention});
        host.ioRead(SAM_CTRL_PORT, rd, v);
        check("ctrl before flag", 16'h1B01, rd);
        host.ioWrite(SAM_CTRL_PORT, 16'h0101);
        tick(FINE_TICKS);
        @(posedge clk_sys);
        dmaCycle <= 1'b1;
        @(posedge clk_sys);
        dmaCycle <= 1'b0;
        tick(FINE_TICKS);
        check("attn after dma", 16'h0000, {15'h0000, localAttention});
        diskChipSelEnable <= 1'b1;
        host.ioRead(DISK_DATA_PORT, rd, v);
        tick(FINE_TICKS);
        check("attn after disk", 16'h0000, {15'h0000, localAttention});
        // request bit 0 is gated off by control bit 15, the other sources below are masked or excluded, so the count runs out
        chipSelHit         <= 1'b1;
        pendingRequestBits <= 16'h0001;
        inServiceBits      <= 16'h8004;
        host.ioRead(16'h0300, rd, v);
        tick(1);
        check("attn masked sources", 16'h0001, {15'h0000, localAttention});
        summarize();
    end

    initial begin
        #200000;
        mismatches++;
        summarize();
    end
endmodule
